// *** common/dtpm_pkg.sv ***
// package for the dual timer with pulse measurement
package dtpm_pkg;
  // ====================================================
  // register map (byte addresses, one word each, stride per timer)
  localparam logic [11:0] DTPM_OFS_START = 12'h000;
  localparam logic [11:0] DTPM_OFS_OVF = 12'h004;
  localparam logic [11:0] DTPM_OFS_MODE0 = 12'h010;
  localparam logic [11:0] DTPM_OFS_DATA0 = 12'h014;
  localparam logic [11:0] DTPM_STRIDE = 12'h010;
  localparam int DTPM_NTIMER = 2;
  localparam int DTPM_W = 16;
  // ====================================================
  // mode register fields
  localparam int DTPM_F_MODE_LO = 0;
  localparam int DTPM_F_EDGE_LO = 2;
  localparam int DTPM_F_MSEL = 4;
  localparam int DTPM_F_SRC = 5;
  localparam int DTPM_F_CKS_LO = 6;
  localparam logic [7:0] DTPM_MODE_RST = 8'h00;
  localparam logic [15:0] DTPM_CNT_RST = 16'hffff;
  // ====================================================
  // prescaler ratios
  localparam int DTPM_DIV8 = 8;
  localparam int DTPM_DIV32 = 32;
  localparam int DTPM_SUBDIV = 32;

  typedef enum logic [1:0] {
    DTPM_TIMER = 2'h0,
    DTPM_EVENT = 2'h1,
    DTPM_MEASURE = 2'h2,
    DTPM_RSVD = 2'h3
  } dtpm_mode_e;

  typedef struct packed {
    logic [1:0] cks;
    logic src;
    logic msel;
    logic [1:0] edge_sel;
    dtpm_mode_e mode;
  } dtpm_mode_s;

  typedef enum logic [2:0] {
    DTPM_MS_IDLE = 3'b001,
    DTPM_MS_FIRST = 3'b010,
    DTPM_MS_RUN = 3'b100
  } dtpm_ms_e;
endpackage : dtpm_pkg

// *** design/dtpm_top.sv ***
// dual 16-bit timer with timer, event counter and pulse measurement modes
//
// Behaviour
// - timer mode counts down on selected clock
// - underflow reloads counter, counting continues
// - underflow rate is source over n+1
// - count only while start flag set
// - underflow raises the interrupt request
// - stopped write loads reload and counter
// - running write loads reload only
// - data read returns live counter
// - event mode counts selected pin edges
// - event mode may count other timer overflow
// - measure mode counts up on internal clock
// - measure edge captures count unless a data write hits that cycle, restarts at zero
// - measure edge interrupts, except first edge
// - up overflow interrupts and sets overflow flag
// - mode write while started clears overflow
// - measure read returns captured value
// - capture undefined before second edge
// - measure mode ignores data writes
// - two timers, mode in bits 1:0
`timescale 1ns/100ps
`default_nettype none
module dtpm_top
  import dtpm_pkg::*;
#(
  parameter int NT = dtpm_pkg::DTPM_NTIMER
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // sub clock divide-by-32 tick and timer input pins
  input wire logic subclk_div_thirtytwo_i,
  input wire logic [NT-1:0] timer_input_pin_i,
  // interrupt requests, one-cycle pulses
  output logic [NT-1:0] irq_o,
  // external overflow sources for event mode
  input wire logic [NT-1:0] ext_ovf_i
);
  import dtpm_pkg::*;

  // ====================================================
  // shared prescaler
  logic [4:0] pre;
  logic [4:0] next_pre;
  logic clk_div_eight;
  logic clk_div_thirtytwo;
  logic clk_undivided;
  always_comb begin
    next_pre = pre + 5'h01;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre <= 5'h00;
    end else begin
      pre <= next_pre;
    end
  end
  assign clk_undivided = 1'b1;
  assign clk_div_eight = (pre[2:0] == 3'(DTPM_DIV8 - 1));
  assign clk_div_thirtytwo = (pre == 5'(DTPM_DIV32 - 1));

  // ====================================================
  // apb decode
  logic acc;
  logic wr;
  logic [NT-1:0] start;
  logic [NT-1:0] next_start;
  logic [NT-1:0] ovf;
  logic [NT-1:0] next_ovf;
  logic [NT-1:0] sel_mode;
  logic [NT-1:0] sel_data;
  logic [DTPM_W-1:0] rd_val [NT];
  dtpm_mode_s mreg [NT];
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [NT-1:0] uflow;
  logic [NT-1:0] next_irq;
  assign acc = psel_i & penable_i & ~pready_o;
  assign wr = acc & pwrite_i;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    sel_mode = '0;
    sel_data = '0;
    if (paddr_i == DTPM_OFS_START) begin
      next_prdata = 32'(start);
    end else if (paddr_i == DTPM_OFS_OVF) begin
      next_prdata = 32'(ovf);
    end else begin
      next_slverr = 1'b1;
      for (int k = 0; k < NT; k++) begin
        if (paddr_i == DTPM_OFS_MODE0 + 12'(k) * DTPM_STRIDE) begin
          sel_mode[k] = 1'b1;
          next_prdata = 32'(mreg[k]);
          next_slverr = 1'b0;
        end else if (paddr_i == DTPM_OFS_DATA0 + 12'(k) * DTPM_STRIDE) begin
          sel_data[k] = 1'b1;
          next_prdata = 32'(rd_val[k]);
          next_slverr = 1'b0;
        end
      end
    end
    next_start = start;
    if (wr && paddr_i == DTPM_OFS_START) begin
      next_start = pwdata_i[NT-1:0];
    end
  end

  // ====================================================
  // per-timer logic
  for (genvar g = 0; g < NT; g++) begin : g_tmr
    logic [DTPM_W-1:0] cnt;
    logic [DTPM_W-1:0] next_cnt;
    logic [DTPM_W-1:0] rld;
    logic [DTPM_W-1:0] next_rld;
    dtpm_mode_s next_m;
    dtpm_ms_e ms;
    dtpm_ms_e next_ms;
    logic pin_q;
    logic pin_qq;
    logic rise;
    logic fall;
    logic pin_edge;
    logic meas_edge;
    logic tick;
    logic ev_tick;
    logic next_uf;
    logic next_ov;
    logic ovsrc;

    // pin sampled into pin_q; second register pin_qq gives edge history
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pin_q <= 1'b0;
        pin_qq <= 1'b0;
      end else begin
        pin_q <= timer_input_pin_i[g];
        pin_qq <= pin_q;
      end
    end
    assign rise = pin_q & ~pin_qq;
    assign fall = ~pin_q & pin_qq;

    always_comb begin
      // internal count clock choice
      case (mreg[g].cks)
        2'h0: tick = clk_undivided;
        2'h1: tick = clk_div_eight;
        2'h2: tick = clk_div_thirtytwo;
        default: tick = subclk_div_thirtytwo_i;
      endcase
      // edge select: 0 rising, 1 falling, 2/3 both
      case (mreg[g].edge_sel)
        2'h0: pin_edge = rise;
        2'h1: pin_edge = fall;
        default: pin_edge = rise | fall;
      endcase
      // other timer overflow source, ring order
      ovsrc = (NT > 1) ? uflow[(g + NT - 1) % NT] : ext_ovf_i[g];
      ev_tick = mreg[g].src ? (ovsrc | ext_ovf_i[g]) : pin_edge;
      // msel 0 period (falling edges), 1 width (both edges)
      meas_edge = mreg[g].msel ? (rise | fall) : fall;
    end

    always_comb begin
      next_cnt = cnt;
      next_rld = rld;
      next_m = mreg[g];
      next_ms = ms;
      next_uf = 1'b0;
      next_ov = 1'b0;
      next_irq[g] = 1'b0;
      if (wr && sel_mode[g]) begin
        next_m = dtpm_mode_s'(pwdata_i[7:0]);
      end
      if (mreg[g].mode == DTPM_MEASURE) begin
        // capture register holds result; writes dropped
        if (!start[g]) begin
          next_ms = DTPM_MS_IDLE;
        end else begin
          if (tick) begin
            next_cnt = cnt + 16'h0001;
            if (cnt == 16'hffff) begin
              next_ov = 1'b1;
              next_irq[g] = 1'b1;
            end
          end
          if (meas_edge) begin
            next_rld = cnt;
            next_cnt = 16'h0000;
            case (ms)
              DTPM_MS_IDLE: next_ms = DTPM_MS_FIRST;
              default: begin
                next_ms = DTPM_MS_RUN;
                next_irq[g] = 1'b1;
              end
            endcase
          end
        end
      end else begin
        next_ms = DTPM_MS_IDLE;
        if (wr && sel_data[g]) begin
          next_rld = pwdata_i[15:0];
          if (!start[g]) begin
            next_cnt = pwdata_i[15:0];
          end
        end
        if (start[g] && ((mreg[g].mode == DTPM_EVENT) ? ev_tick : tick)) begin
          if (cnt == 16'h0000) begin
            next_cnt = next_rld;
            next_uf = 1'b1;
            next_irq[g] = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      // set wins over the clear on the overflow flag
      if (next_ov) begin
        next_ovf[g] = 1'b1;
      end else if (wr && sel_mode[g] && start[g]) begin
        next_ovf[g] = 1'b0;
      end else begin
        next_ovf[g] = ovf[g];
      end
    end
    assign rd_val[g] = (mreg[g].mode == DTPM_MEASURE) ? rld : cnt;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt <= DTPM_CNT_RST;
        rld <= DTPM_CNT_RST;
        mreg[g] <= dtpm_mode_s'(DTPM_MODE_RST);
        ms <= DTPM_MS_IDLE;
        uflow[g] <= 1'b0;
      end else begin
        cnt <= next_cnt;
        rld <= (wr && sel_data[g] && mreg[g].mode == DTPM_MEASURE) ? rld : next_rld;
        mreg[g] <= next_m;
        ms <= next_ms;
        uflow[g] <= next_uf;
      end
    end
  end

  // ====================================================
  // shared registers and bus outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start <= '0;
      ovf <= '0;
      irq_o <= '0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      start <= next_start;
      ovf <= next_ovf;
      irq_o <= next_irq;
      pready_o <= acc;
      prdata_o <= acc ? next_prdata : 32'h0000_0000;
      pslverr_o <= acc & next_slverr;
    end
  end
endmodule : dtpm_top
`default_nettype wire

// *** testbench/dtpm_chk.sv ***
// apb response checker for the dual timer
`timescale 1ns/100ps
`default_nettype none
module dtpm_chk (
  // clock, reset and apb
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  // ====
  // properties
  logic map;
  assign map = paddr_i inside {12'h000, 12'h004, 12'h010, 12'h014, 12'h020, 12'h024};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wait_state_a: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("late ready");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("long ready");
  ready_cause_a: assert property (pready_o |-> psel_i && penable_i && $past(penable_i)) else $error("stray ready");
  data_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("data off ready");
  unmapped_err_a: assert property (pready_o && !map |-> pslverr_o && prdata_o == 32'h0) else $error("no error");
  err_cause_a: assert property (pslverr_o |-> pready_o && !map) else $error("stray error");
  upper_zero_a: assert property (pready_o |-> prdata_o[31:16] == 16'h0) else $error("upper bits");
  flag_bits_a: assert property (pready_o && !pwrite_i && paddr_i[11:3] == 9'h0 |-> prdata_o[31:2] == 30'h0)
    else $error("flag bits");
endmodule : dtpm_chk
bind dtpm_top dtpm_chk u_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
  .pslverr_o);
`default_nettype wire

// *** testbench/dtpm_pulse_src.sv ***
// pulse source model for a timer input pin
`timescale 1ns/100ps
`default_nettype none
module dtpm_pulse_src (
  // control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] lo_i,
  // pin level
  output logic pin_o
);
  // ====
  // levels move only after clock edges; low while disabled
  logic [7:0] cnt = 8'h00;
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    cnt <= (cnt == 8'h00) ? (pin_o ? lo_i : hi_i) - 8'h01 : cnt - 8'h01;
    if (cnt == 8'h00) pin_o <= !pin_o;
    if (!en_i) begin
      cnt <= 8'h00;
      pin_o <= 1'b0;
    end
  end
endmodule : dtpm_pulse_src
`default_nettype wire

// *** testbench/dtpm_top_test.sv ***
// self-checking bench for the dual timer
`timescale 1ns/100ps
`default_nettype none
module dtpm_top_test;
  import dtpm_pkg::*;
  // ====
  // signals
  logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, sub, pen, pin, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, n, seed = 32'h56;
  logic [1:0] irq_o;
  logic [7:0] hi, lo;
  int n_errors = 0, checks = 0, cyc = 0, gap, t0;
  logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h020, 12'h024, 12'h030};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'hffff, 32'h0, 32'hffff, 32'h0};
  dtpm_top dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .subclk_div_thirtytwo_i(sub), .timer_input_pin_i({pin, 1'b0}), .irq_o, .ext_ovf_i(2'b00));
  dtpm_pulse_src src (.clk_i, .en_i(pen), .hi_i(hi), .lo_i(lo), .pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // sub tick every 32 cycles; overflow run dominates the time budget
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    sub <= cyc % 32 == 31;
    if (cyc == 80000) begin
      n_errors++;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic int tgap(input int c, input int v);
    return (c == 0 ? 1 : c == 1 ? DTPM_DIV8 : c == 2 ? DTPM_DIV32 : 32) * (v + 1);
  endfunction : tgap
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask : apb
  task automatic wirq(input int i);
    do @(posedge clk_i); while (irq_o[i] !== 1'b1);
  endtask : wirq
  task automatic gapm(input int i);
    wirq(i);
    t0 = cyc;
    wirq(i);
    gap = cyc - t0;
  endtask : gapm
  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // ====
  // main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pen, hi, lo} = '0;
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (ra[k]) begin
      apb(1'b0, ra[k], 32'h0);
      chk(rd, rv[k]);
      chk(err, k == 6);
    end
    for (int c = 0; c < 4; c++) begin
      n = rnd() & 32'h7;
      apb(1'b1, 12'h010, c << 6);
      apb(1'b1, 12'h014, n);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd, n);
      apb(1'b1, 12'h000, 32'h1);
      gapm(0);
      chk(gap, tgap(c, n));
      apb(1'b1, 12'h000, 32'h0);
    end
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h014, 32'h40);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h014, 32'h3);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd > 32'h3 && rd < 32'h40, 1'b1);
    gapm(0);
    chk(gap, 4);
    hi <= 8'h03;
    lo <= 8'h05;
    pen <= 1'b1;
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, 12'h020, e == 3 ? 32'h21 : 32'h1 | e << 2);
      apb(1'b1, 12'h024, 32'h1);
      apb(1'b1, 12'h000, e == 3 ? 32'h3 : 32'h2);
      gapm(1);
      chk(gap, e > 1 ? 8 : 16);
      apb(1'b1, 12'h000, 32'h0);
    end
    pen <= 1'b0;
    hi <= 8'(4 + (rnd() & 32'h7));
    lo <= 8'(20 + (rnd() & 32'hf));
    apb(1'b1, 12'h020, 32'h2);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h024, 32'h55);
    pen <= 1'b1;
    t0 = cyc;
    wirq(1);
    chk(cyc - t0 > hi + lo, 1'b1);
    gapm(1);
    chk(gap, hi + lo);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd == hi + lo || rd == hi + lo - 1, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    pen <= 1'b0;
    apb(1'b1, 12'h000, 32'h2);
    t0 = cyc;
    wirq(1);
    chk(cyc - t0 > 65000, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 12'h020, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : dtpm_top_test
`default_nettype wire
